/* File: gpp_board.sv */
/*
  gpp_board: board circuitry on one port's pins.
  Assumes the device drives when oe is high; an undriven pin without pull-up floats.
*/
`default_nettype none
module gpp_board #(
  parameter int W = 4
) (
  // clock
  input  wire logic         pclk,
  // device side
  input  wire logic [W-1:0] o,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] pu,
  // board drivers, low W bits used
  input  wire logic [7:0]   drv_en,
  input  wire logic [7:0]   drv_val,
  output logic      [W-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] flt_r = '0;
  // a floating pin changes every cycle so no stale level survives
  always @(posedge pclk) flt_r <= ~flt_r;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin[i] = oe[i] ? o[i] : drv_en[i] ? drv_val[i] : pu[i] ? 1'b1 : flt_r[i];
    end
  end
endmodule : gpp_board
`default_nettype wire

/* File: gpp_pin.sv */
/*
  gpp_pin: pad-side logic for one port: two-flop input synchroniser, output enable
  and pull-up gating. Assumes direction bit 1 means input.
*/
`default_nettype none
module gpp_pin
  import gpp_pkg::*;
#(
  parameter int unsigned W = 4
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // register side
  input  wire logic [W-1:0] dir_in,
  input  wire logic [W-1:0] out_val,
  input  wire logic [W-1:0] pu_sel,
  output logic      [W-1:0] pin_sync,
  // pad side
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] pin_pu
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = pin_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign pin_sync = sync_r;
  assign pin_o    = out_val;
  assign pin_oe   = ~dir_in;
  assign pin_pu   = pu_sel & dir_in;
endmodule : gpp_pin
`default_nettype wire

/* File: gpp_pkg.sv */
/*
  gpp_pkg: register offsets, field positions, reset values and port widths for the
  general-purpose port block. Assumes a 32-bit APB register bus with word-aligned byte offsets.
*/
`default_nettype none
package gpp_pkg;
  // port widths
  localparam int unsigned GPP_P0_W = 4;
  localparam int unsigned GPP_P1_W = 4;
  localparam int unsigned GPP_P2_W = 7;
  localparam int unsigned GPP_P3_W = 4;
  localparam int unsigned GPP_P5_W = 4;
  localparam int unsigned GPP_AW   = 8;
  // register byte offsets
  localparam logic [7:0] GPP_OUT0_OFS  = 8'h00;
  localparam logic [7:0] GPP_OUT1_OFS  = 8'h04;
  localparam logic [7:0] GPP_OUT2_OFS  = 8'h08;
  localparam logic [7:0] GPP_OUT3_OFS  = 8'h0c;
  localparam logic [7:0] GPP_OUT5_OFS  = 8'h10;
  localparam logic [7:0] GPP_DIR0_OFS  = 8'h20;
  localparam logic [7:0] GPP_DIR1_OFS  = 8'h24;
  localparam logic [7:0] GPP_DIR2_OFS  = 8'h28;
  localparam logic [7:0] GPP_DIR3_OFS  = 8'h2c;
  localparam logic [7:0] GPP_DIR5_OFS  = 8'h30;
  localparam logic [7:0] GPP_PUOA_OFS  = 8'h40;
  localparam logic [7:0] GPP_KRM_OFS   = 8'h44;
  localparam logic [7:0] GPP_BPU2_OFS  = 8'h48;
  localparam logic [7:0] GPP_BPU3_OFS  = 8'h4c;
  localparam logic [7:0] GPP_IN0_OFS   = 8'h60;
  localparam logic [7:0] GPP_IN1_OFS   = 8'h64;
  localparam logic [7:0] GPP_IN2_OFS   = 8'h68;
  localparam logic [7:0] GPP_IN3_OFS   = 8'h6c;
  localparam logic [7:0] GPP_IN5_OFS   = 8'h70;
  // field positions in the pull-up option and key return mode registers
  localparam int unsigned GPP_PUOA_P0_BIT = 0;
  localparam int unsigned GPP_PUOA_P1_BIT = 1;
  localparam int unsigned GPP_KRM_PU_BIT  = 0;
  // reset values: direction 1 = input
  localparam logic [7:0] GPP_DIR_RST = 8'hff;
  localparam logic [7:0] GPP_OUT_RST = 8'h00;
  localparam logic [7:0] GPP_PU_RST  = 8'h00;
endpackage : gpp_pkg
`default_nettype wire

/* File: gpp_port.sv */
/*
  gpp_port: five general-purpose I/O ports with per-bit direction, output latches,
  pull-up control on ports 0 to 3 and an APB register slave. Assumes pins are synchronised inside,
  and pads resolve level from pin_o, pin_oe and pin_pu.
*/
// Summary of operation
// - each pin's direction is chosen by its own bit, independent of others
// - port 0 and port 1 pull-ups each switch port-wide from their own bit of the option register
// - key return mode register can also enable port 0 pull-ups
// - ports 2 and 3 have per-bit pull-up enable registers
// - pull-up applies only while the pin is an input
`default_nettype none
module gpp_port
  import gpp_pkg::*;
(
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [GPP_AW-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // port 0 pins
  input  wire logic [GPP_P0_W-1:0] port0_pins_i,
  output logic      [GPP_P0_W-1:0] port0_pins_o,
  output logic      [GPP_P0_W-1:0] port0_pins_oe,
  output logic      [GPP_P0_W-1:0] port0_pins_pu,
  // port 1 pins
  input  wire logic [GPP_P1_W-1:0] port1_pins_i,
  output logic      [GPP_P1_W-1:0] port1_pins_o,
  output logic      [GPP_P1_W-1:0] port1_pins_oe,
  output logic      [GPP_P1_W-1:0] port1_pins_pu,
  // port 2 pins
  input  wire logic [GPP_P2_W-1:0] port2_pins_i,
  output logic      [GPP_P2_W-1:0] port2_pins_o,
  output logic      [GPP_P2_W-1:0] port2_pins_oe,
  output logic      [GPP_P2_W-1:0] port2_pins_pu,
  // port 3 pins
  input  wire logic [GPP_P3_W-1:0] port3_pins_i,
  output logic      [GPP_P3_W-1:0] port3_pins_o,
  output logic      [GPP_P3_W-1:0] port3_pins_oe,
  output logic      [GPP_P3_W-1:0] port3_pins_pu,
  // port 5 pins
  input  wire logic [GPP_P5_W-1:0] port5_pins_i,
  output logic      [GPP_P5_W-1:0] port5_pins_o,
  output logic      [GPP_P5_W-1:0] port5_pins_oe,
  output logic      [GPP_P5_W-1:0] port5_pins_pu,
  // key return inputs for the key scan logic
  output logic      [GPP_P0_W-1:0] key_return_inputs
);
  // registers (direction 1 = input)
  logic [GPP_P0_W-1:0] out0_r, out0_nxt, dir0_r, dir0_nxt;
  logic [GPP_P1_W-1:0] out1_r, out1_nxt, dir1_r, dir1_nxt;
  logic [GPP_P2_W-1:0] out2_r, out2_nxt, dir2_r, dir2_nxt;
  logic [GPP_P3_W-1:0] out3_r, out3_nxt, dir3_r, dir3_nxt;
  logic [GPP_P5_W-1:0] out5_r, out5_nxt, dir5_r, dir5_nxt;
  logic [1:0]          port_pullup_option_a_r, port_pullup_option_a_nxt;
  logic                key_return_mode_reg_r, key_return_mode_reg_nxt;
  logic [GPP_P2_W-1:0] port2_bitwise_pullup_reg_r, port2_bitwise_pullup_reg_nxt;
  logic [GPP_P3_W-1:0] port3_bitwise_pullup_reg_r, port3_bitwise_pullup_reg_nxt;
  logic [31:0]         prdata_r, prdata_nxt;
  logic                pslverr_nxt;
  logic                access;
  logic                wr;
  logic                hit;
  logic [GPP_P0_W-1:0] in0;
  logic [GPP_P1_W-1:0] in1;
  logic [GPP_P2_W-1:0] in2;
  logic [GPP_P3_W-1:0] in3;
  logic [GPP_P5_W-1:0] in5;
  logic                pu0_on;
  logic                pu1_on;

  // pad read value: input pins show the pin, output pins show the latch
  function automatic logic [31:0] rd_port(input logic [7:0] dir, input logic [7:0] pin, input logic [7:0] lat);
    rd_port = {24'h000000, (dir & pin) | (~dir & lat)};
  endfunction : rd_port

  assign access = psel & penable;
  assign wr     = access & pwrite;
  assign pready = access;

  // port-wide pull-up selects for ports 0 and 1
  assign pu0_on = port_pullup_option_a_r[GPP_PUOA_P0_BIT]
                | key_return_mode_reg_r;
  assign pu1_on = port_pullup_option_a_r[GPP_PUOA_P1_BIT];

  always_comb begin
    out0_nxt = out0_r;
    out1_nxt = out1_r;
    out2_nxt = out2_r;
    out3_nxt = out3_r;
    out5_nxt = out5_r;
    dir0_nxt = dir0_r;
    dir1_nxt = dir1_r;
    dir2_nxt = dir2_r;
    dir3_nxt = dir3_r;
    dir5_nxt = dir5_r;
    port_pullup_option_a_nxt      = port_pullup_option_a_r;
    key_return_mode_reg_nxt       = key_return_mode_reg_r;
    port2_bitwise_pullup_reg_nxt  = port2_bitwise_pullup_reg_r;
    port3_bitwise_pullup_reg_nxt  = port3_bitwise_pullup_reg_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    hit         = 1'b1;
    // read data is captured in the setup cycle so it stands through the access phase
    if (psel && !penable) begin
      prdata_nxt = 32'h00000000;
      unique case (paddr)
        GPP_OUT0_OFS: prdata_nxt = {28'h0000000, out0_r};
        GPP_OUT1_OFS: prdata_nxt = {28'h0000000, out1_r};
        GPP_OUT2_OFS: prdata_nxt = {25'h0000000, out2_r};
        GPP_OUT3_OFS: prdata_nxt = {28'h0000000, out3_r};
        GPP_OUT5_OFS: prdata_nxt = {28'h0000000, out5_r};
        GPP_DIR0_OFS: prdata_nxt = {28'h0000000, dir0_r};
        GPP_DIR1_OFS: prdata_nxt = {28'h0000000, dir1_r};
        GPP_DIR2_OFS: prdata_nxt = {25'h0000000, dir2_r};
        GPP_DIR3_OFS: prdata_nxt = {28'h0000000, dir3_r};
        GPP_DIR5_OFS: prdata_nxt = {28'h0000000, dir5_r};
        GPP_PUOA_OFS: prdata_nxt = {30'h00000000, port_pullup_option_a_r};
        GPP_KRM_OFS:  prdata_nxt = {31'h00000000, key_return_mode_reg_r};
        GPP_BPU2_OFS: prdata_nxt = {25'h0000000, port2_bitwise_pullup_reg_r};
        GPP_BPU3_OFS: prdata_nxt = {28'h0000000, port3_bitwise_pullup_reg_r};
        GPP_IN0_OFS:  prdata_nxt = rd_port({4'h0, dir0_r}, {4'h0, in0}, {4'h0, out0_r});
        GPP_IN1_OFS:  prdata_nxt = rd_port({4'h0, dir1_r}, {4'h0, in1}, {4'h0, out1_r});
        GPP_IN2_OFS:  prdata_nxt = rd_port({1'b0, dir2_r}, {1'b0, in2}, {1'b0, out2_r});
        GPP_IN3_OFS:  prdata_nxt = rd_port({4'h0, dir3_r}, {4'h0, in3}, {4'h0, out3_r});
        GPP_IN5_OFS:  prdata_nxt = rd_port({4'h0, dir5_r}, {4'h0, in5}, {4'h0, out5_r});
        default:      prdata_nxt = 32'h00000000;
      endcase
    end
    // writes land at the access edge; unmapped offsets and pin read-back writes raise pslverr
    if (access) begin
      unique case (paddr)
        GPP_OUT0_OFS: if (pwrite) out0_nxt = pwdata[GPP_P0_W-1:0];
        GPP_OUT1_OFS: if (pwrite) out1_nxt = pwdata[GPP_P1_W-1:0];
        GPP_OUT2_OFS: if (pwrite) out2_nxt = pwdata[GPP_P2_W-1:0];
        GPP_OUT3_OFS: if (pwrite) out3_nxt = pwdata[GPP_P3_W-1:0];
        GPP_OUT5_OFS: if (pwrite) out5_nxt = pwdata[GPP_P5_W-1:0];
        GPP_DIR0_OFS: if (pwrite) dir0_nxt = pwdata[GPP_P0_W-1:0];
        GPP_DIR1_OFS: if (pwrite) dir1_nxt = pwdata[GPP_P1_W-1:0];
        GPP_DIR2_OFS: if (pwrite) dir2_nxt = pwdata[GPP_P2_W-1:0];
        GPP_DIR3_OFS: if (pwrite) dir3_nxt = pwdata[GPP_P3_W-1:0];
        GPP_DIR5_OFS: if (pwrite) dir5_nxt = pwdata[GPP_P5_W-1:0];
        GPP_PUOA_OFS: if (pwrite) port_pullup_option_a_nxt = pwdata[1:0];
        GPP_KRM_OFS:  if (pwrite) key_return_mode_reg_nxt = pwdata[GPP_KRM_PU_BIT];
        GPP_BPU2_OFS: if (pwrite) port2_bitwise_pullup_reg_nxt = pwdata[GPP_P2_W-1:0];
        GPP_BPU3_OFS: if (pwrite) port3_bitwise_pullup_reg_nxt = pwdata[GPP_P3_W-1:0];
        GPP_IN0_OFS, GPP_IN1_OFS, GPP_IN2_OFS, GPP_IN3_OFS, GPP_IN5_OFS: hit = !wr;
        default: hit = 1'b0;
      endcase
      pslverr_nxt = !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out0_r <= GPP_OUT_RST[GPP_P0_W-1:0];
      out1_r <= GPP_OUT_RST[GPP_P1_W-1:0];
      out2_r <= GPP_OUT_RST[GPP_P2_W-1:0];
      out3_r <= GPP_OUT_RST[GPP_P3_W-1:0];
      out5_r <= GPP_OUT_RST[GPP_P5_W-1:0];
      dir0_r <= GPP_DIR_RST[GPP_P0_W-1:0];
      dir1_r <= GPP_DIR_RST[GPP_P1_W-1:0];
      dir2_r <= GPP_DIR_RST[GPP_P2_W-1:0];
      dir3_r <= GPP_DIR_RST[GPP_P3_W-1:0];
      dir5_r <= GPP_DIR_RST[GPP_P5_W-1:0];
      port_pullup_option_a_r     <= GPP_PU_RST[1:0];
      key_return_mode_reg_r      <= GPP_PU_RST[0];
      port2_bitwise_pullup_reg_r <= GPP_PU_RST[GPP_P2_W-1:0];
      port3_bitwise_pullup_reg_r <= GPP_PU_RST[GPP_P3_W-1:0];
      prdata_r  <= 32'h00000000;
    end else begin
      out0_r <= out0_nxt;
      out1_r <= out1_nxt;
      out2_r <= out2_nxt;
      out3_r <= out3_nxt;
      out5_r <= out5_nxt;
      dir0_r <= dir0_nxt;
      dir1_r <= dir1_nxt;
      dir2_r <= dir2_nxt;
      dir3_r <= dir3_nxt;
      dir5_r <= dir5_nxt;
      port_pullup_option_a_r     <= port_pullup_option_a_nxt;
      key_return_mode_reg_r      <= key_return_mode_reg_nxt;
      port2_bitwise_pullup_reg_r <= port2_bitwise_pullup_reg_nxt;
      port3_bitwise_pullup_reg_r <= port3_bitwise_pullup_reg_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // error flag is decoded in the access cycle, alongside pready
  assign prdata  = prdata_r;
  assign pslverr = access & (pslverr_nxt);
  assign key_return_inputs = in0;

  gpp_pin #(.W(GPP_P0_W)) u_p0 (
    .pclk(pclk), .presetn(presetn), .dir_in(dir0_r), .out_val(out0_r),
    .pu_sel({GPP_P0_W{pu0_on}}), .pin_sync(in0), .pin_i(port0_pins_i),
    .pin_o(port0_pins_o), .pin_oe(port0_pins_oe), .pin_pu(port0_pins_pu));
  gpp_pin #(.W(GPP_P1_W)) u_p1 (
    .pclk(pclk), .presetn(presetn), .dir_in(dir1_r), .out_val(out1_r),
    .pu_sel({GPP_P1_W{pu1_on}}), .pin_sync(in1), .pin_i(port1_pins_i),
    .pin_o(port1_pins_o), .pin_oe(port1_pins_oe), .pin_pu(port1_pins_pu));
  gpp_pin #(.W(GPP_P2_W)) u_p2 (
    .pclk(pclk), .presetn(presetn), .dir_in(dir2_r), .out_val(out2_r),
    .pu_sel(port2_bitwise_pullup_reg_r), .pin_sync(in2), .pin_i(port2_pins_i),
    .pin_o(port2_pins_o), .pin_oe(port2_pins_oe), .pin_pu(port2_pins_pu));
  gpp_pin #(.W(GPP_P3_W)) u_p3 (
    .pclk(pclk), .presetn(presetn), .dir_in(dir3_r), .out_val(out3_r),
    .pu_sel(port3_bitwise_pullup_reg_r), .pin_sync(in3), .pin_i(port3_pins_i),
    .pin_o(port3_pins_o), .pin_oe(port3_pins_oe), .pin_pu(port3_pins_pu));
  gpp_pin #(.W(GPP_P5_W)) u_p5 (
    .pclk(pclk), .presetn(presetn), .dir_in(dir5_r), .out_val(out5_r),
    .pu_sel({GPP_P5_W{1'b0}}), .pin_sync(in5), .pin_i(port5_pins_i),
    .pin_o(port5_pins_o), .pin_oe(port5_pins_oe), .pin_pu(port5_pins_pu));
endmodule : gpp_port
`default_nettype wire

/* File: gpp_port_assertions.sv */
/*
  gpp_port_chk: assertions on the port block's pins and APB side.
  Assumes it is bound to gpp_port.
*/
`default_nettype none
module gpp_port_chk
  import gpp_pkg::*;
(
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [GPP_AW-1:0]   paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [GPP_P0_W-1:0] port0_pins_oe,
  input wire logic [GPP_P0_W-1:0] port0_pins_pu,
  input wire logic [GPP_P1_W-1:0] port1_pins_oe,
  input wire logic [GPP_P1_W-1:0] port1_pins_pu,
  input wire logic [GPP_P2_W-1:0] port2_pins_oe,
  input wire logic [GPP_P2_W-1:0] port2_pins_pu,
  input wire logic [GPP_P3_W-1:0] port3_pins_oe,
  input wire logic [GPP_P3_W-1:0] port3_pins_pu
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  assign wr = psel && penable && pwrite;
  AST_RST_ALL_IN: assert property ($rose(presetn) |-> !(|{port0_pins_oe, port1_pins_oe, port2_pins_oe, port3_pins_oe}))
    else $error("pin driven right after reset");
  AST_DIR0_WRITE: assert property (wr && paddr == GPP_DIR0_OFS |=> port0_pins_oe == ~$past(pwdata[3:0]))
    else $error("port 0 enables do not follow direction write");
  AST_DIR2_HOLD: assert property (!(wr && paddr == GPP_DIR2_OFS) |=> $stable(port2_pins_oe))
    else $error("port 2 enables moved without a write");
  AST_P0_PU_GATED: assert property ((port0_pins_pu & port0_pins_oe) == 4'h0)
    else $error("port 0 pull-up on an output");
  AST_P2_PU_GATED: assert property ((port2_pins_pu & port2_pins_oe) == 7'h00)
    else $error("port 2 pull-up on an output");
  AST_P3_PU_GATED: assert property ((port3_pins_pu & port3_pins_oe) == 4'h0)
    else $error("port 3 pull-up on an output");
  AST_P1_PU_UNIFORM: assert property (port1_pins_pu == 4'h0 || port1_pins_pu == ~port1_pins_oe)
    else $error("port 1 pull-ups not port wide");
  AST_P0_PU_UNIFORM: assert property (port0_pins_pu == 4'h0 || port0_pins_pu == ~port0_pins_oe)
    else $error("port 0 pull-ups not port wide");
  cover property (wr && paddr == GPP_KRM_OFS);
  cover property (port2_pins_pu != 7'h00 && port2_pins_oe != 7'h00);
  cover property ($rose(presetn));
endmodule : gpp_port_chk
`default_nettype wire

/* File: gpp_port_tb_top.sv */
/*
  gpp_port_tb_top: register rows, pin read-back and reset checks for gpp_port.
  Assumes zero-wait APB and a two-flop input synchroniser.
*/
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module gpp_port_tb_top
  import gpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [7:0] d; int p; logic [7:0] oe; logic [7:0] pu;} gpp_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, den, dval;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  logic [3:0] p0i, p0o, p0e, p0u, p1i, p1o, p1e, p1u, p3i, p3o, p3e, p3u, p5i, p5o, p5e, p5u, kri;
  logic [6:0] p2i, p2o, p2e, p2u;
  int errors = 0, comparisons = 0;
  gpp_row_s rows [11] = '{'{GPP_PUOA_OFS, 8'h01, 0, 8'h00, 8'h0f}, '{GPP_PUOA_OFS, 8'h03, 1, 8'h00, 8'h0f},
    '{GPP_DIR0_OFS, 8'h05, 0, 8'h0a, 8'h05}, '{GPP_PUOA_OFS, 8'h02, 0, 8'h0a, 8'h00},
    '{GPP_KRM_OFS, 8'h01, 0, 8'h0a, 8'h05}, '{GPP_BPU2_OFS, 8'h55, 2, 8'h00, 8'h55},
    '{GPP_DIR2_OFS, 8'h70, 2, 8'h0f, 8'h50}, '{GPP_BPU3_OFS, 8'h09, 3, 8'h00, 8'h09},
    '{GPP_DIR3_OFS, 8'h06, 3, 8'h09, 8'h00}, '{GPP_DIR5_OFS, 8'h03, 5, 8'h0c, 8'h00},
    '{GPP_DIR1_OFS, 8'h0e, 1, 8'h01, 8'h0e}};
  gpp_port gpp_port_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .port0_pins_i(p0i), .port0_pins_o(p0o), .port0_pins_oe(p0e), .port0_pins_pu(p0u),
    .port1_pins_i(p1i), .port1_pins_o(p1o), .port1_pins_oe(p1e), .port1_pins_pu(p1u),
    .port2_pins_i(p2i), .port2_pins_o(p2o), .port2_pins_oe(p2e), .port2_pins_pu(p2u),
    .port3_pins_i(p3i), .port3_pins_o(p3o), .port3_pins_oe(p3e), .port3_pins_pu(p3u),
    .port5_pins_i(p5i), .port5_pins_o(p5o), .port5_pins_oe(p5e), .port5_pins_pu(p5u), .key_return_inputs(kri));
  gpp_board #(.W(4)) gpp_board_inst0 (.pclk, .o(p0o), .oe(p0e), .pu(p0u), .drv_en(den), .drv_val(dval), .pin(p0i));
  gpp_board #(.W(4)) gpp_board_inst1 (.pclk, .o(p1o), .oe(p1e), .pu(p1u), .drv_en(den), .drv_val(dval), .pin(p1i));
  gpp_board #(.W(7)) gpp_board_inst2 (.pclk, .o(p2o), .oe(p2e), .pu(p2u), .drv_en(den), .drv_val(dval), .pin(p2i));
  gpp_board #(.W(4)) gpp_board_inst3 (.pclk, .o(p3o), .oe(p3e), .pu(p3u), .drv_en(den), .drv_val(dval), .pin(p3i));
  gpp_board #(.W(4)) gpp_board_inst5 (.pclk, .o(p5o), .oe(p5e), .pu(p5u), .drv_en(den), .drv_val(dval), .pin(p5i));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task conclude();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("ERROR t=%0t pready %h exp %h", $time, pready, 1'b1);
      conclude();
    end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  function automatic logic [15:0] pick(int p);
    case (p)
      0: pick = {8'(p0e), 8'(p0u)};
      1: pick = {8'(p1e), 8'(p1u)};
      2: pick = {8'(p2e), 8'(p2u)};
      3: pick = {8'(p3e), 8'(p3u)};
      default: pick = {8'(p5e), 8'(p5u)};
    endcase
  endfunction : pick
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    den = 8'h00; dval = 8'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({p0e, p1e, p2e, p3e, p5e, p0u, p1u, p2u, p3u, p5u}, 46'h0)
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, 32'(rows[i].d));
      `CHK(pick(rows[i].p), {rows[i].oe, rows[i].pu})
    end
    apb(1'b1, GPP_OUT0_OFS, 32'h2);
    repeat (2) @(posedge pclk);
    apb(1'b0, GPP_IN0_OFS, 32'h0);
    `CHK(rd, 32'h7)
    den <= 8'h05;
    repeat (3) @(posedge pclk);
    `CHK(kri, 4'h2)
    den <= 8'h7f;
    dval <= 8'h5a;
    apb(1'b1, GPP_OUT1_OFS, 32'h5);
    apb(1'b1, GPP_OUT2_OFS, 32'h25);
    apb(1'b1, GPP_OUT3_OFS, 32'h9);
    apb(1'b1, GPP_OUT5_OFS, 32'h9);
    `CHK({p1o, p2o, p3o, p5o}, {4'h5, 7'h25, 4'h9, 4'h9})
    apb(1'b0, GPP_IN1_OFS, 32'h0);
    `CHK(rd, 32'hb)
    apb(1'b0, GPP_IN2_OFS, 32'h0);
    `CHK(rd, 32'h55)
    apb(1'b0, GPP_IN3_OFS, 32'h0);
    `CHK(rd, 32'hb)
    apb(1'b0, GPP_IN5_OFS, 32'h0);
    `CHK(rd, 32'ha)
    apb(1'b0, GPP_DIR2_OFS, 32'h0);
    `CHK(rd, 32'h70)
    apb(1'b0, GPP_BPU2_OFS, 32'h0);
    `CHK(rd, 32'h55)
    apb(1'b0, GPP_PUOA_OFS, 32'h0);
    `CHK(rd, 32'h2)
    apb(1'b0, GPP_KRM_OFS, 32'h0);
    `CHK(rd, 32'h1)
    apb(1'b1, GPP_IN0_OFS, 32'hf);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h80, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK({p0e, p1e, p2e, p3e, p5e, p0u, p1u, p2u, p3u, p5u, p0o, p2o}, 57'h0)
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, GPP_DIR2_OFS, 32'h0);
    `CHK(rd, 32'h7f)
    conclude();
  end
endmodule : gpp_port_tb_top
bind gpp_port gpp_port_chk gpp_port_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .port0_pins_oe, .port0_pins_pu, .port1_pins_oe, .port1_pins_pu, .port2_pins_oe, .port2_pins_pu,
  .port3_pins_oe, .port3_pins_pu);
`default_nettype wire
